/* design/lbc_core.sv */
// lbc_core: digital control of a cold-cathode lamp driver, both variants.
// assumes scl/sda and all pins synchronous to mclk; open-drain sda as in/out/oe.
`timescale 1ns/1ps

module lbc_core #(
    parameter bit SMBUS_VARIANT = 1'b1     // 1 = serial variant, 0 = counter variant
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // counter variant pins
    input  wire logic               count_up_in,
    input  wire logic               count_down_in,
    input  wire logic               power_off_n_pin,
    // serial variant pins
    input  wire logic               latch_select_pin,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    // analog interface
    input  wire logic               open_tube_trip,   // sense above reference
    input  wire logic               cur_limit_trip,   // current sense above limit
    input  wire logic               freq_fast_pin,    // sync pin at reference level
    input  wire logic               sync_pin,
    output lbc_pkg::lbc_ctl_type    ctl
);

    // ==========================================================
    // synchronisers and edge detection
    // ==========================================================
    logic [1:0] up_s_r;        // up synchroniser
    logic [1:0] dn_s_r;        // down synchroniser
    logic       up_d_r;        // up history
    logic       dn_d_r;        // down history
    logic [1:0] scl_s_r;       // scl synchroniser
    logic [1:0] sda_s_r;       // sda synchroniser
    logic       scl_d_r;       // scl history
    logic       sda_d_r;       // sda history

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            up_s_r  <= 2'h0;
            dn_s_r  <= 2'h0;
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
        end else begin
            up_s_r  <= {up_s_r[0], count_up_in};
            dn_s_r  <= {dn_s_r[0], count_down_in};
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
        end
    end

    // edge history from the second stage only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            up_d_r  <= 1'b0;
            dn_d_r  <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            up_d_r  <= up_s_r[1];
            dn_d_r  <= dn_s_r[1];
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    logic up_rise;     // clean up edge
    logic dn_rise;     // clean down edge
    logic both_hi;     // preset condition
    assign up_rise = up_s_r[1] && !up_d_r;
    assign dn_rise = dn_s_r[1] && !dn_d_r;
    assign both_hi = up_s_r[1] && dn_s_r[1];

    // ==========================================================
    // counter variant
    // ==========================================================
    logic [4:0] count_r;       // brightness count

    // count runs regardless of the shutdown pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_r <= lbc_pkg::LEVEL_MID;
        end else if (both_hi) begin
            count_r <= lbc_pkg::LEVEL_MID;
        end else if (up_rise && !dn_rise) begin
            if (count_r != 5'h1F) begin
                count_r <= count_r + 5'h01;
            end
        end else if (dn_rise && !up_rise) begin
            if (count_r != 5'h00) begin
                count_r <= count_r - 5'h01;
            end
        end
    end

    // ==========================================================
    // serial slave
    // ==========================================================
    lbc_pkg::lbc_bus_type state_r;   // bus state
    logic [7:0]  shift_r;            // shift register
    logic [3:0]  bit_r;              // bit counter
    logic        rd_r;               // transaction is a read
    logic        pend_r;             // byte received, waiting for stop
    logic [7:0]  pend_byte_r;        // received byte
    logic        sda_low_r;          // drive sda low
    logic [6:0]  latch0_r;           // configuration latch zero
    logic [6:0]  latch1_r;           // configuration latch one
    logic        ok_flag_r;          // open-tube ok flag
    logic [7:0]  status;             // status byte

    logic scl_rise;   // sampling edge
    logic scl_fall;   // shifting edge
    logic start_c;    // start condition
    logic stop_c;     // stop condition
    assign scl_rise = scl_s_r[1] && !scl_d_r;
    assign scl_fall = !scl_s_r[1] && scl_d_r;
    assign start_c  = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
    assign stop_c   = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];

    // bus state machine; address check, byte capture, read shift
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r   <= lbc_pkg::BUS_IDLE;
            shift_r   <= 8'h00;
            bit_r     <= 4'h0;
            rd_r      <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (start_c) begin
            state_r   <= lbc_pkg::BUS_ADDR;
            bit_r     <= 4'h0;
            sda_low_r <= 1'b0;
        end else if (stop_c) begin
            state_r   <= lbc_pkg::BUS_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                lbc_pkg::BUS_ADDR, lbc_pkg::BUS_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s_r[1]};
                        bit_r   <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        if (state_r == lbc_pkg::BUS_ADDR) begin
                            if (shift_r[7:1] == lbc_pkg::SLAVE_ADDR) begin
                                rd_r      <= shift_r[0];
                                sda_low_r <= 1'b1;
                                state_r   <= lbc_pkg::BUS_ACK;
                            end else begin
                                state_r <= lbc_pkg::BUS_SKIP;
                            end
                        end else begin
                            sda_low_r <= 1'b1;
                            state_r   <= lbc_pkg::BUS_ACK;
                        end
                    end
                end
                lbc_pkg::BUS_ACK: begin
                    // after the ack clock, release for a write or drive the first status bit for a read
                    if (scl_fall) begin
                        bit_r <= 4'h0;
                        if (rd_r) begin
                            shift_r   <= status;
                            sda_low_r <= !status[7];
                            state_r   <= lbc_pkg::BUS_RDATA;
                        end else begin
                            sda_low_r <= 1'b0;
                            state_r   <= pend_r ? lbc_pkg::BUS_SKIP : lbc_pkg::BUS_WDATA;
                        end
                    end
                end
                lbc_pkg::BUS_RDATA: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h7) begin
                            sda_low_r <= 1'b0;
                            state_r   <= lbc_pkg::BUS_RACK;
                        end else begin
                            shift_r   <= {shift_r[6:0], 1'b0};
                            sda_low_r <= !shift_r[6];
                        end
                    end
                end
                lbc_pkg::BUS_RACK: begin
                    // one byte only; the master's ack slot ends it, ack or nack
                    if (scl_fall) begin
                        state_r <= lbc_pkg::BUS_SKIP;
                    end
                end
                default: begin
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    // single data byte held until stop
    // commit at stop, drop on restart
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_r      <= 1'b0;
            pend_byte_r <= 8'h00;
        end else if (start_c || stop_c) begin
            pend_r <= 1'b0;
        end else if (state_r == lbc_pkg::BUS_WDATA && scl_fall && bit_r == 4'h8) begin
            pend_r      <= 1'b1;
            pend_byte_r <= shift_r;
        end
    end

    // latches always writable, even in shutdown
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch0_r <= lbc_pkg::LATCH0_RST;
            latch1_r <= lbc_pkg::LATCH1_RST;
        end else if (stop_c && pend_r) begin
            if (!pend_byte_r[lbc_pkg::LATCH_PICK_POS]) begin
                latch0_r <= pend_byte_r[6:0];
            end else begin
                latch1_r <= pend_byte_r[6:0];
            end
        end
    end

    // ==========================================================
    // operating control
    // ==========================================================
    lbc_pkg::lbc_cfg_type cfg;   // active configuration
    logic lamp_en;               // lamp may run
    logic idle_mode;             // shutdown or standby
    logic sw_on;                 // timer switch gate

    always_comb begin
        if (!SMBUS_VARIANT) begin
            cfg.full_off_n  = power_off_n_pin;
            cfg.lamp_hold_n = 1'b1;
            cfg.level       = count_r;
        end else if (!latch_select_pin) begin
            cfg = latch0_r;
        end else begin
            cfg = latch1_r;
        end
    end

    assign idle_mode = !cfg.full_off_n || !cfg.lamp_hold_n;

    // lamp off when code zero, shutdown or standby
    assign lamp_en = !idle_mode && (cfg.level != 5'h00);

    // flag cleared on fault, set by shutdown or standby
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ok_flag_r <= 1'b1;
        end else if (open_tube_trip) begin
            ok_flag_r <= 1'b0;
        end else if (idle_mode) begin
            ok_flag_r <= 1'b1;
        end
    end

    assign status = {ok_flag_r, lbc_pkg::STATUS_ONES, cfg.level};

    // switch cycle timer
    lbc_switch_timer u_timer (
        .mclk      (mclk),
        .rst       (rst),
        .fast_sel  (freq_fast_pin),
        .sync_in   (sync_pin),
        .enable    (lamp_en),
        .cur_trip  (open_tube_trip || cur_limit_trip),
        .switch_on (sw_on)
    );

    logic       ref_on_r;      // reference and regulator on
    logic       soft_gnd_r;    // soft-start held at ground
    logic [4:0] dac_code_r;    // brightness code to the dac
    // registered analog controls
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_on_r   <= 1'b0;
            soft_gnd_r <= 1'b1;
            dac_code_r <= lbc_pkg::LEVEL_MID;
        end else begin
            ref_on_r   <= cfg.full_off_n;
            soft_gnd_r <= !lamp_en;
            dac_code_r <= cfg.level;
        end
    end

    // switch forced off on open tube
    assign ctl = {ref_on_r, sw_on && lamp_en && !open_tube_trip, soft_gnd_r, dac_code_r};

    // open-drain data line
    assign sda_out = 1'b0;
    assign sda_oe  = SMBUS_VARIANT && sda_low_r;

endmodule

/* shared/lbc_pkg.sv */
// lbc_pkg: constants and carrier types for the lamp brightness control block.
// assumes a single 250 MHz clock domain; all pins are sampled synchronously.
package lbc_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_MHZ           = 250;     // core clock rate
    localparam int SLOW_FREQ_KHZ     = 145;     // low switching frequency
    localparam int FAST_FREQ_KHZ     = 290;     // high switching frequency
    localparam int SLOW_PERIOD_CYC   = (CLK_MHZ * 1000) / SLOW_FREQ_KHZ;
    localparam int FAST_PERIOD_CYC   = (CLK_MHZ * 1000) / FAST_FREQ_KHZ;

    // ==========================================================
    // bus address and configuration byte fields
    // ==========================================================
    localparam logic [6:0] SLAVE_ADDR    = 7'h2D;   // 0101101 binary
    localparam int         LATCH_PICK_POS = 7;      // latch select bit of config byte
    localparam int         FULL_OFF_POS   = 6;      // full-off bar bit
    localparam int         LAMP_HOLD_POS  = 5;      // standby bar bit
    localparam int         LEVEL_MSB      = 4;      // level code top bit
    localparam int         OK_FLAG_POS    = 7;      // status: open-tube ok flag

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [4:0] LEVEL_MID     = 5'h10;   // mid-scale 10000
    localparam logic [6:0] LATCH0_RST    = 7'h10;   // off 0, hold 0, level 10000
    localparam logic [6:0] LATCH1_RST    = 7'h70;   // off 1, hold 1, level 10000
    localparam logic [1:0] STATUS_ONES   = 2'h3;    // status bits 6:5

    // ==========================================================
    // carrier types
    // ==========================================================
    typedef struct packed {
        logic       full_off_n;     // 0 = full shutdown
        logic       lamp_hold_n;    // 0 = standby
        logic [4:0] level;          // dac code
    } lbc_cfg_type;

    typedef struct packed {
        logic       ref_on;         // reference and regulator fully on
        logic       switch_on;      // power switch gate
        logic       soft_gnd;       // soft-start node shorted to ground
        logic [4:0] dac_code;       // brightness dac input
    } lbc_ctl_type;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_ADDR  = 3'b001,
        BUS_WDATA = 3'b010,
        BUS_RDATA = 3'b011,
        BUS_ACK   = 3'b100,
        BUS_RACK  = 3'b101,
        BUS_SKIP  = 3'b110
    } lbc_bus_type;

endpackage

/* design/lbc_switch_timer.sv */
// lbc_switch_timer: power switch cycle timer with sync restart.
// assumes frequency select already decoded and sync pin synchronous to mclk.
`timescale 1ns/1ps

module lbc_switch_timer #(
    parameter int SLOW_CYC = lbc_pkg::SLOW_PERIOD_CYC,
    parameter int FAST_CYC = lbc_pkg::FAST_PERIOD_CYC
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // control
    input  wire logic fast_sel,     // 1 = fast frequency
    input  wire logic sync_in,      // sync pin level
    input  wire logic enable,       // lamp allowed to run
    input  wire logic cur_trip,     // current limit or open-tube kill
    // output
    output logic      switch_on     // registered switch gate
);

    // ==========================================================
    // checks and storage
    // ==========================================================
    if (SLOW_CYC < 2 || FAST_CYC < 2 || SLOW_CYC >= 65536 || FAST_CYC >= 65536) begin
        $error("lbc_switch_timer: bad period");
    end

    logic [15:0] cnt_r;       // cycle counter
    logic        sync_d_r;    // previous sync level
    logic        start;       // begin a new switch cycle
    logic [15:0] period;      // chosen period

    assign period = fast_sel ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1);

    assign start = (sync_in && !sync_d_r) || (cnt_r >= period);

    // sync edge history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
        end else if (start) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // switch gate: on at cycle start, off on trip
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            switch_on <= 1'b0;
        end else if (!enable || cur_trip) begin
            switch_on <= 1'b0;
        end else if (start) begin
            switch_on <= 1'b1;
        end
    end

endmodule

/* testbench/lbc_core_asserts.sv */
// lbc_core_asserts: port checks for the lamp control core.
// assumes a bind to every lbc_core instance, one mclk domain.
`timescale 1ns/1ps

module lbc_core_asserts #(
    parameter bit SMBUS_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // pins
    input wire logic                 count_up_in,
    input wire logic                 count_down_in,
    input wire logic                 power_off_n_pin,
    input wire logic                 scl_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire logic                 open_tube_trip,
    // analog controls
    input wire lbc_pkg::lbc_ctl_type ctl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ========
    // lamp gating
    // ========
    // level zero grounds soft-start
    zero_soft_a: assert property (ctl.dac_code == 5'h00 |-> ctl.soft_gnd)
        else $error("soft-start free at level zero");
    // shutdown grounds soft-start
    off_soft_a: assert property (!ctl.ref_on |-> ctl.soft_gnd)
        else $error("soft-start free in shutdown");
    // settled shutdown keeps switch off
    off_switch_a: assert property (!ctl.ref_on [*3] |-> !ctl.switch_on)
        else $error("switch on in shutdown");
    // open tube kills switch at once
    open_kill_a: assert property (open_tube_trip |-> !ctl.switch_on)
        else $error("switch on with open tube");
    // ========
    // serial pins
    // ========
    // data line only ever pulled low
    sda_low_a: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    // data changes only while clock low
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved with clock high");
    // ========
    // counter variant
    // ========
    // both inputs high pins mid-scale
    mid_hold_a: assert property ((!SMBUS_VARIANT && count_up_in && count_down_in) [*6]
        |-> ctl.dac_code == 5'h10) else $error("count not at mid-scale");
    // count moves by one or presets, never wraps
    one_step_a: assert property (!SMBUS_VARIANT && $changed(ctl.dac_code)
        |-> {1'b0, ctl.dac_code} == {1'b0, $past(ctl.dac_code)} + 6'd1
        || {1'b0, $past(ctl.dac_code)} == {1'b0, ctl.dac_code} + 6'd1
        || ctl.dac_code == 5'h10) else $error("count jumped");
    // shutdown pin turns analog off
    sleep_ref_a: assert property ((!SMBUS_VARIANT && !power_off_n_pin) [*3] |-> !ctl.ref_on)
        else $error("reference on in shutdown");
endmodule

bind lbc_core lbc_core_asserts #(.SMBUS_VARIANT(SMBUS_VARIANT)) chk_u (.mclk(mclk), .rst(rst),
    .count_up_in(count_up_in), .count_down_in(count_down_in), .power_off_n_pin(power_off_n_pin),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .open_tube_trip(open_tube_trip), .ctl(ctl));

/* testbench/lbc_smbus_host.sv */
// lbc_smbus_host: serial bus host model with pull-up wires.
// assumes tasks are called from the bench at mclk falling edges.
`timescale 1ns/1ps

module lbc_smbus_host (
    // clock
    input wire logic mclk,
    // device pull-down
    input wire logic dev_sda_oe,
    // resolved lines
    output logic     scl,
    output logic     sda
);
    logic scl_low_r = 1'b0;    // host holds clock low
    logic sda_low_r = 1'b0;    // host holds data low
    // released lines float high
    assign scl = ~scl_low_r;
    assign sda = ~(sda_low_r | dev_sda_oe);
    // one bus phase, above the four-cycle minimum
    task automatic half();
        repeat (5) @(negedge mclk);
    endtask
    task automatic start();
        sda_low_r = 1'b1;
        half();
        scl_low_r = 1'b1;
        half();
    endtask
    task automatic stop();
        sda_low_r = 1'b1;
        half();
        scl_low_r = 1'b0;
        half();
        sda_low_r = 1'b0;
        half();
    endtask
    task automatic put_bit(input logic o, output logic b);
        sda_low_r = ~o;
        half();
        scl_low_r = 1'b0;
        half();
        b = sda;
        scl_low_r = 1'b1;
        half();
    endtask
    // msb first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i], b);
        put_bit(1'b1, b);
        ack = ~b;
    endtask
    // one address byte and one data byte, both acknowledged
    task automatic write_cfg(input logic [6:0] addr, input logic [7:0] data, output logic ack);
        logic dack;
        start();
        send_byte({addr, 1'b0}, ack);
        send_byte(data, dack);
        stop();
        ack = ack & dack;
    endtask
    // status byte, closed by a not-acknowledge
    task automatic read_status(output logic [7:0] st, output logic ack);
        logic b;
        start();
        send_byte({lbc_pkg::SLAVE_ADDR, 1'b1}, ack);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, st[i]);
        put_bit(1'b1, b);
        stop();
    endtask
endmodule

/* testbench/lbc_core_test.sv */
// lbc_core_test: scenarios for both variants of the lamp control core.
// assumes a serial instance and a counter instance share all inputs.
`timescale 1ns/1ps

module lbc_core_test;
    // ========
    // signals
    // ========
    logic                 mclk, rst, count_up_in, count_down_in, power_off_n_pin, latch_select_pin;
    logic                 open_tube_trip, cur_limit_trip, freq_fast_pin, sync_pin, scl, sda, sda_oe;
    lbc_pkg::lbc_ctl_type ctl;      // serial instance controls
    lbc_pkg::lbc_ctl_type cnt_ctl;  // counter instance controls
    int                   errors, samples_checked;
    logic [7:0]           st;
    logic                 ak;
    lbc_core #(.SMBUS_VARIANT(1'b1)) dut_u (.mclk(mclk), .rst(rst), .count_up_in(count_up_in),
        .count_down_in(count_down_in), .power_off_n_pin(power_off_n_pin),
        .latch_select_pin(latch_select_pin), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .open_tube_trip(open_tube_trip), .cur_limit_trip(cur_limit_trip),
        .freq_fast_pin(freq_fast_pin), .sync_pin(sync_pin), .ctl(ctl));
    lbc_core #(.SMBUS_VARIANT(1'b0)) dut_cnt_u (.mclk(mclk), .rst(rst), .count_up_in(count_up_in),
        .count_down_in(count_down_in), .power_off_n_pin(power_off_n_pin),
        .latch_select_pin(latch_select_pin), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(),
        .open_tube_trip(open_tube_trip), .cur_limit_trip(cur_limit_trip),
        .freq_fast_pin(freq_fast_pin), .sync_pin(sync_pin), .ctl(cnt_ctl));
    lbc_smbus_host host_u (.mclk(mclk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
    // 250 MHz clock
    always #2 mclk = ~mclk;
    // ========
    // helpers
    // ========
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_cfg(input logic on, input logic gnd, input logic [4:0] lvl);
        check8("ctl_cfg", {1'b0, on, gnd, lvl}, {1'b0, ctl.ref_on, ctl.soft_gnd, ctl.dac_code});
    endtask
    task automatic wr(input logic [7:0] d);
        host_u.write_cfg(lbc_pkg::SLAVE_ADDR, d, ak);
        cyc(2);
    endtask
    task automatic sel(input logic s);
        latch_select_pin = s;
        cyc(4);
    endtask
    // does the switch turn on within n cycles
    task automatic watch_sw(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            cyc(1);
            seen = seen | ctl.switch_on;
        end
    endtask
    // cut the switch by current limit, count cycles to the next start
    task automatic rise(output int n);
        cur_limit_trip = 1'b1;
        cyc(2);
        cur_limit_trip = 1'b0;
        n = 2;
        while (ctl.switch_on && n < 10) begin cyc(1); n++; end
        while (!ctl.switch_on && n < 4000) begin cyc(1); n++; end
    endtask
    task automatic pulse(input int n, input logic up, input logic dn);
        repeat (n) begin
            count_up_in = up;
            count_down_in = dn;
            cyc(4);
            count_up_in = 1'b0;
            count_down_in = 1'b0;
            cyc(4);
        end
    endtask
    task automatic check_cnt(input logic [4:0] lvl);
        check8("count", {3'h0, lvl}, {3'h0, cnt_ctl.dac_code});
    endtask
    // ========
    // scenarios
    // ========
    task automatic t_latches();
        check_cfg(1'b0, 1'b1, 5'h10);
        host_u.read_status(st, ak);
        check8("status", 8'hF0, st);
        sel(1'b1);
        check_cfg(1'b1, 1'b0, 5'h10);
        sel(1'b0);
        wr(8'h6B);
        check8("addr_ack", 8'h01, {7'h0, ak});
        check_cfg(1'b1, 1'b0, 5'h0B);
        wr(8'hFF);
        check_cfg(1'b1, 1'b0, 5'h0B);
        sel(1'b1);
        check_cfg(1'b1, 1'b0, 5'h1F);
        host_u.read_status(st, ak);
        check8("status", 8'hFF, st);
        sel(1'b0);
        host_u.write_cfg(7'h2C, 8'h00, ak);
        check8("addr_ack", 8'h00, {7'h0, ak});
        check_cfg(1'b1, 1'b0, 5'h0B);
    endtask
    task automatic t_modes();
        logic seen;
        wr(8'h4B);
        check_cfg(1'b1, 1'b1, 5'h0B);
        watch_sw(1800, seen);
        check8("switch_seen", 8'h00, {7'h0, seen});
        wr(8'h2B);
        check_cfg(1'b0, 1'b1, 5'h0B);
        wr(8'h60);
        check_cfg(1'b1, 1'b1, 5'h00);
        wr(8'h6B);
        check_cfg(1'b1, 1'b0, 5'h0B);
        watch_sw(1800, seen);
        check8("switch_seen", 8'h01, {7'h0, seen});
    endtask
    task automatic t_open_tube();
        logic seen;
        open_tube_trip = 1'b1;
        watch_sw(1800, seen);
        check8("switch_seen", 8'h00, {7'h0, seen});
        open_tube_trip = 1'b0;
        host_u.read_status(st, ak);
        check8("status", 8'h6B, st);
        wr(8'h4B);
        wr(8'h6B);
        host_u.read_status(st, ak);
        check8("status", 8'hEB, st);
    endtask
    task automatic t_freq(input logic fast, input int exp);
        int n;
        freq_fast_pin = fast;
        rise(n);
        rise(n);
        rise(n);
        check8("period_ok", 8'h01, {7'h0, (n >= exp - 1 && n <= exp + 1)});
    endtask
    task automatic t_sync();
        int n;
        rise(n);
        rise(n);
        cur_limit_trip = 1'b1;
        cyc(2);
        cur_limit_trip = 1'b0;
        cyc(4);
        check8("switch_on", 8'h00, {7'h0, ctl.switch_on});
        sync_pin = 1'b1;
        cyc(6);
        check8("switch_on", 8'h01, {7'h0, ctl.switch_on});
        sync_pin = 1'b0;
    endtask
    task automatic t_counter();
        check_cnt(5'h10);
        pulse(3, 1'b1, 1'b0);
        check_cnt(5'h13);
        pulse(5, 1'b0, 1'b1);
        check_cnt(5'h0E);
        pulse(16, 1'b0, 1'b1);
        check_cnt(5'h00);
        power_off_n_pin = 1'b0;
        pulse(2, 1'b1, 1'b0);
        check8("ref_on", 8'h00, {7'h0, cnt_ctl.ref_on});
        check_cnt(5'h02);
        power_off_n_pin = 1'b1;
        pulse(32, 1'b1, 1'b0);
        check_cnt(5'h1F);
        count_up_in = 1'b1;
        count_down_in = 1'b1;
        cyc(8);
        check_cnt(5'h10);
        count_down_in = 1'b0;
        cyc(6);
        count_up_in = 1'b0;
        cyc(6);
        check_cnt(5'h10);
    endtask
    // ========
    // verdict and main sequence
    // ========
    task automatic finish_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        {mclk, count_up_in, count_down_in, latch_select_pin} = 4'h0;
        {open_tube_trip, cur_limit_trip, freq_fast_pin, sync_pin} = 4'h0;
        {rst, power_off_n_pin} = 2'h3;
        errors = 0;
        samples_checked = 0;
        cyc(5);
        rst = 1'b0;
        cyc(2);
        t_latches();
        t_modes();
        t_open_tube();
        t_freq(1'b0, (250 * 1000) / 145);
        t_freq(1'b1, (250 * 1000) / 290);
        t_sync();
        t_counter();
        finish_test();
    end
    // hang guard, well past the expected run
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        finish_test();
    end
endmodule
